/* File: include/dpm_consts.svh */
`ifndef DPM_CONSTS_SVH
`define DPM_CONSTS_SVH

// Register byte addresses
`define DPM_ADDR_CTRL 12'h000
`define DPM_ADDR_OFFSET 12'h004
`define DPM_ADDR_AUXCFG 12'h008
`define DPM_ADDR_STATUS 12'h00C
`define DPM_ADDR_FREQ_MEASURE_PART_ONE 12'h010
`define DPM_ADDR_FREQ_MEASURE_PART_TWO 12'h014
`define DPM_ADDR_FREQ_MEASURE_PART_THREE 12'h018
`define DPM_ADDR_PHASE_MEASURE_PART_ONE 12'h01C
`define DPM_ADDR_PHASE_MEASURE_PART_TWO 12'h020
`define DPM_ADDR_BW 12'h024

// Control register fields
`define DPM_CTRL_BUILD_OUT_ENABLE 0
`define DPM_CTRL_RECALIBRATION_REQUEST_REQUEST 1
`define DPM_CTRL_CROSS_MEAS 2
`define DPM_CTRL_MEAS_SRC 3
`define DPM_CTRL_RESET 32'h0000_0000

// Offset: signed 17 bit, 6 ps per step, +/-200 ns
`define DPM_OFFSET_STEP_PS 6
`define DPM_OFFSET_SPAN_PS 200000
`define DPM_OFFSET_MAX 17'sd33333
`define DPM_OFFSET_MIN -17'sd33333

// Frequency and phase measurement
`define DPM_FREQ_MAX 24'sd260756
`define DPM_FREQ_MIN -24'sd260756
`define DPM_PHASE_AVG_SHIFT 4

// Bandwidth selections
`define DPM_MAIN_BW_POSITIONS 4'd13
`define DPM_AUX_BW_POSITIONS 2'd3

// Ramp: one offset step per tick, divider reset pulse length
`define DPM_RAMP_NS 20
`define DPM_CLK_NS 20
`define DPM_RAMP_CYCLES ((`DPM_RAMP_NS + `DPM_CLK_NS - 1) / `DPM_CLK_NS)
`define DPM_DIVRST_CYCLES 4

// Locking modes
`define DPM_LOCK_DIRECT 2'b00
`define DPM_LOCK_8K 2'b01
`define DPM_LOCK_DIV8K 2'b10
`define DPM_LOCK_INTEGER_DIVIDE_MODE 2'b11

`endif

/* File: include/dpm_pkg.sv */
package dpm_pkg;
	typedef enum logic [2:0] {
		DPM_IDLE = 3'b000,
		DPM_HOLD = 3'b001,
		DPM_RAMP_ZERO = 3'b010,
		DPM_DIV_RESET = 3'b011,
		DPM_RAMP_BACK = 3'b100,
		DPM_RELEASE = 3'b101
	} dpm_recalibration_request_e;

	typedef enum logic [1:0] {
		DPM_ST_FREERUN = 2'b00,
		DPM_ST_HOLDOVER = 2'b01,
		DPM_ST_LOCKING = 2'b10,
		DPM_ST_LOCKED = 2'b11
	} dpm_loop_e;

	typedef struct packed {
		logic signed [23:0] freq;
		logic signed [15:0] phase;
	} dpm_meas_s;
endpackage

/* File: hw/dpm_top.sv */
`timescale 1ns/1ps
`include "dpm_consts.svh"

module dpm_top
	import dpm_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire dpm_loop_e main_loop_state,
	input wire logic build_out_event,
	input wire dpm_meas_s main_meas,
	input wire dpm_meas_s aux_meas,
	input wire logic [1:0] main_ref_lock_mode,
	input wire logic [1:0] forced_ref_lock_mode,
	output logic signed [16:0] feedback_offset,
	output logic mini_holdover,
	output logic divider_reset,
	output logic build_out_allowed,
	output logic aux_lock_disable,
	output logic [3:0] aux_forced_input_select,
	output logic [1:0] copy_lock_mode,
	output logic [3:0] main_bw_select,
	output logic [1:0] aux_bw_select
);
	logic [31:0] ctrl_reg;
	logic signed [16:0] offset_reg;
	logic signed [16:0] target_reg;
	dpm_recalibration_request_e recalibration_request_reg;
	logic [2:0] divcnt_reg;
	logic [7:0] tick_reg;
	logic signed [23:0] freq_reg;
	logic signed [15:0] phase_reg;
	logic signed [19:0] phase_acc_reg;
	logic signed [23:0] freq_src;
	logic signed [15:0] phase_src;
	logic [31:0] rdata_next;
	logic wr_en;
	logic rd_hit;
	logic held_state;
	logic ramp_tick;
	logic signed [16:0] wr_offset;
	logic signed [16:0] ramp_goal;
	logic recalibration_request_start;

	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign held_state = (main_loop_state == DPM_ST_FREERUN)
		|| (main_loop_state == DPM_ST_HOLDOVER);
	assign ramp_tick = (tick_reg == 8'(`DPM_RAMP_CYCLES - 1));
	assign recalibration_request_start = wr_en && (paddr == `DPM_ADDR_CTRL)
		&& pwdata[`DPM_CTRL_RECALIBRATION_REQUEST_REQUEST] && (recalibration_request_reg == DPM_IDLE);

	// Saturate the written offset to the +/-200 ns span
	always_comb
	begin
		wr_offset = signed'(pwdata[16:0]);
		if (wr_offset > `DPM_OFFSET_MAX)
			wr_offset = `DPM_OFFSET_MAX;
		else if (wr_offset < `DPM_OFFSET_MIN)
			wr_offset = `DPM_OFFSET_MIN;
	end

	// Control and configuration registers
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			ctrl_reg <= `DPM_CTRL_RESET;
			target_reg <= 17'sd0;
			aux_forced_input_select <= 4'h0;
			main_bw_select <= 4'h0;
			aux_bw_select <= 2'h0;
		end
		else if (wr_en)
		begin
			unique case (paddr)
				`DPM_ADDR_CTRL:
				begin
					ctrl_reg <= {28'h0, pwdata[3], pwdata[2], 1'b0, pwdata[0]};
				end
				`DPM_ADDR_OFFSET:
				begin
					target_reg <= wr_offset;
				end
				`DPM_ADDR_AUXCFG:
				begin
					aux_forced_input_select <= pwdata[3:0];
				end
				`DPM_ADDR_BW:
				begin
					if (pwdata[3:0] < `DPM_MAIN_BW_POSITIONS)
						main_bw_select <= pwdata[3:0];
					if (pwdata[9:8] < `DPM_AUX_BW_POSITIONS)
						aux_bw_select <= pwdata[9:8];
				end
				default:
				begin
				end
			endcase
		end
	end

	assign build_out_allowed = ctrl_reg[`DPM_CTRL_BUILD_OUT_ENABLE];
	// Aux locking off while comparing against the main reference copy
	assign aux_lock_disable = ctrl_reg[`DPM_CTRL_CROSS_MEAS];

	// Copy locking mode; direct-forced and non-8k divide stay direct
	always_comb
	begin
		copy_lock_mode = `DPM_LOCK_DIRECT;
		if (ctrl_reg[`DPM_CTRL_CROSS_MEAS]
			&& ((forced_ref_lock_mode == `DPM_LOCK_8K)
			|| (forced_ref_lock_mode == `DPM_LOCK_DIV8K)))
		begin
			unique case (main_ref_lock_mode)
				`DPM_LOCK_DIRECT: copy_lock_mode = `DPM_LOCK_8K;
				`DPM_LOCK_8K: copy_lock_mode = `DPM_LOCK_8K;
				`DPM_LOCK_DIV8K: copy_lock_mode = `DPM_LOCK_DIV8K;
				`DPM_LOCK_INTEGER_DIVIDE_MODE: copy_lock_mode = `DPM_LOCK_DIRECT;
			endcase
		end
	end

	// Ramp pacing: during recalibration the loop sees small steps, not one phase jump
	always_ff @(posedge clk)
	begin
		if (!resetn || ramp_tick)
			tick_reg <= 8'h00;
		else
			tick_reg <= tick_reg + 8'h01;
	end

	// Recalibration sequencer
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			recalibration_request_reg <= DPM_IDLE;
			divcnt_reg <= 3'd0;
		end
		else
		begin
			unique case (recalibration_request_reg)
				DPM_IDLE:
				begin
					if (recalibration_request_start)
						recalibration_request_reg <= DPM_HOLD;
				end
				DPM_HOLD:
				begin
					recalibration_request_reg <= DPM_RAMP_ZERO;
				end
				DPM_RAMP_ZERO:
				begin
					if (offset_reg == 17'sd0)
					begin
						recalibration_request_reg <= DPM_DIV_RESET;
						divcnt_reg <= 3'd0;
					end
				end
				DPM_DIV_RESET:
				begin
					divcnt_reg <= divcnt_reg + 3'd1;
					if (divcnt_reg == 3'(`DPM_DIVRST_CYCLES - 1))
						recalibration_request_reg <= DPM_RAMP_BACK;
				end
				DPM_RAMP_BACK:
				begin
					if (offset_reg == target_reg)
						recalibration_request_reg <= DPM_RELEASE;
				end
				DPM_RELEASE:
				begin
					recalibration_request_reg <= DPM_IDLE;
				end
				default:
				begin
					recalibration_request_reg <= DPM_IDLE;
				end
			endcase
		end
	end

	assign mini_holdover = (recalibration_request_reg != DPM_IDLE) && (recalibration_request_reg != DPM_RELEASE);
	assign divider_reset = (recalibration_request_reg == DPM_DIV_RESET);

	// Goal of the applied feedback offset
	always_comb
	begin
		if (recalibration_request_reg == DPM_RAMP_ZERO || recalibration_request_reg == DPM_HOLD
			|| recalibration_request_reg == DPM_DIV_RESET)
			ramp_goal = 17'sd0;
		else if (recalibration_request_reg == DPM_RAMP_BACK)
			ramp_goal = target_reg;
		else if (build_out_allowed)
			ramp_goal = offset_reg;
		else
			ramp_goal = target_reg;
	end

	// Applied offset; frozen in free-run or holdover unless recalibrating, so no hit appears
	always_ff @(posedge clk)
	begin
		if (!resetn)
			offset_reg <= 17'sd0;
		else if (recalibration_request_reg != DPM_IDLE && recalibration_request_reg != DPM_RELEASE && ramp_tick)
		begin
			if (offset_reg < ramp_goal)
				offset_reg <= offset_reg + 17'sd1;
			else if (offset_reg > ramp_goal)
				offset_reg <= offset_reg - 17'sd1;
		end
		else if (recalibration_request_reg == DPM_IDLE && !held_state)
			offset_reg <= ramp_goal;
	end

	// Only the feedback synthesizer sees it; loop bandwidth shapes output
	assign feedback_offset = offset_reg;

	// Measurement source select
	always_comb
	begin
		if (ctrl_reg[`DPM_CTRL_MEAS_SRC])
		begin
			freq_src = aux_meas.freq;
			phase_src = aux_meas.phase;
		end
		else
		begin
			freq_src = main_meas.freq;
			phase_src = main_meas.phase;
		end
	end

	// Frequency sample clamped; phase averaged by a one-pole filter
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			freq_reg <= 24'sd0;
			phase_acc_reg <= 20'sd0;
			phase_reg <= 16'sd0;
		end
		else
		begin
			if (freq_src > `DPM_FREQ_MAX)
				freq_reg <= `DPM_FREQ_MAX;
			else if (freq_src < `DPM_FREQ_MIN)
				freq_reg <= `DPM_FREQ_MIN;
			else
				freq_reg <= freq_src;
			phase_acc_reg <= phase_acc_reg + 20'(phase_src)
				- (phase_acc_reg >>> `DPM_PHASE_AVG_SHIFT);
			phase_reg <= 16'(phase_acc_reg >>> `DPM_PHASE_AVG_SHIFT);
		end
	end

	// Read decode; unmapped reads give zero with pslverr
	always_comb
	begin
		rd_hit = 1'b1;
		rdata_next = 32'h0000_0000;
		unique case (paddr)
			`DPM_ADDR_CTRL: rdata_next = ctrl_reg;
			`DPM_ADDR_OFFSET: rdata_next = {{15{target_reg[16]}}, target_reg};
			`DPM_ADDR_AUXCFG: rdata_next = {28'h0, aux_forced_input_select};
			`DPM_ADDR_STATUS: rdata_next = {24'h0, 3'(recalibration_request_reg), 3'h0,
				mini_holdover, recalibration_request_reg != DPM_IDLE};
			`DPM_ADDR_FREQ_MEASURE_PART_ONE: rdata_next = {24'h0, freq_reg[7:0]};
			`DPM_ADDR_FREQ_MEASURE_PART_TWO: rdata_next = {24'h0, freq_reg[15:8]};
			`DPM_ADDR_FREQ_MEASURE_PART_THREE: rdata_next = {24'h0, freq_reg[23:16]};
			`DPM_ADDR_PHASE_MEASURE_PART_ONE: rdata_next = {24'h0, phase_reg[7:0]};
			`DPM_ADDR_PHASE_MEASURE_PART_TWO: rdata_next = {24'h0, phase_reg[15:8]};
			`DPM_ADDR_BW: rdata_next = {22'h0, aux_bw_select, 4'h0, main_bw_select};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= rdata_next;
	end

	always_comb
	begin
		pslverr = psel && penable && !rd_hit;
	end
endmodule

/* File: verification/dpm_top_assertions.sv */
`timescale 1ns/1ps
`include "dpm_consts.svh"
module dpm_top_assertions
	import dpm_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire dpm_loop_e main_loop_state,
	input wire logic [1:0] main_ref_lock_mode,
	input wire logic [1:0] forced_ref_lock_mode,
	input wire logic signed [16:0] feedback_offset,
	input wire logic mini_holdover,
	input wire logic divider_reset,
	input wire logic build_out_allowed,
	input wire logic aux_lock_disable,
	input wire logic [3:0] aux_forced_input_select,
	input wire logic [1:0] copy_lock_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire logic wr = psel && penable && pwrite;
	function automatic logic [1:0] copy_exp(input logic [1:0] f, input logic [1:0] m);
		if (f == `DPM_LOCK_8K || f == `DPM_LOCK_DIV8K)
			return (m == `DPM_LOCK_INTEGER_DIVIDE_MODE) ? `DPM_LOCK_DIRECT : (m == `DPM_LOCK_DIV8K) ? m : `DPM_LOCK_8K;
		return `DPM_LOCK_DIRECT;
	endfunction
	property p_err; psel && penable
		|-> pslverr == (paddr > `DPM_ADDR_BW || paddr[1:0] != 2'b00); endproperty
	a_err: assert property (p_err) else $error("slave error mismatch");
	property p_defer; !main_loop_state[1] && !$past(main_loop_state[1]) && !mini_holdover
		&& !$past(mini_holdover) |-> $stable(feedback_offset); endproperty
	a_defer: assert property (p_defer) else $error("offset moved in holdover");
	property p_frozen; build_out_allowed && $past(build_out_allowed) && !mini_holdover
		&& !$past(mini_holdover) |-> $stable(feedback_offset); endproperty
	a_frozen: assert property (p_frozen) else $error("offset moved with build-out");
	property p_ramp; mini_holdover && $past(mini_holdover)
		|-> feedback_offset - $past(feedback_offset) inside {-17'sd1, 17'sd0, 17'sd1}; endproperty
	a_ramp: assert property (p_ramp) else $error("offset stepped");
	property p_divlen; $rose(divider_reset) |-> divider_reset[*4] ##1 !divider_reset; endproperty
	a_divlen: assert property (p_divlen) else $error("divider reset length");
	property p_divzero; divider_reset |-> feedback_offset == 17'sd0 && mini_holdover; endproperty
	a_divzero: assert property (p_divzero) else $error("divider reset order");
	property p_go; wr && paddr == `DPM_ADDR_CTRL && pwdata[`DPM_CTRL_RECALIBRATION_REQUEST_REQUEST]
		&& !mini_holdover && !$past(mini_holdover) |-> ##[1:2] mini_holdover; endproperty
	a_go: assert property (p_go) else $error("recalibration did not start");
	property p_ctrl; wr && paddr == `DPM_ADDR_CTRL |=> aux_lock_disable == $past(pwdata[2])
		&& build_out_allowed == $past(pwdata[0]); endproperty
	a_ctrl: assert property (p_ctrl) else $error("control bits wrong");
	property p_forced; wr && paddr == `DPM_ADDR_AUXCFG
		|=> aux_forced_input_select == $past(pwdata[3:0]); endproperty
	a_forced: assert property (p_forced) else $error("forced input wrong");
	property p_copy; aux_lock_disable
		|-> copy_lock_mode == copy_exp(forced_ref_lock_mode, main_ref_lock_mode); endproperty
	a_copy: assert property (p_copy) else $error("copy mode wrong");
endmodule
bind dpm_top dpm_top_assertions dpm_top_assertions_i (.clk, .resetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pslverr, .main_loop_state, .main_ref_lock_mode, .forced_ref_lock_mode,
	.feedback_offset, .mini_holdover, .divider_reset, .build_out_allowed, .aux_lock_disable,
	.aux_forced_input_select, .copy_lock_mode);

/* File: verification/dpm_top_tb_top.sv */
`timescale 1ns/1ps
`include "dpm_consts.svh"
module dpm_top_tb_top
	import dpm_pkg::*;
;
	logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, build_out_event = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd, prdata;
	logic [1:0] main_ref_lock_mode = 2'h0, forced_ref_lock_mode = 2'h0, copy_lock_mode;
	dpm_loop_e main_loop_state = DPM_ST_LOCKED;
	dpm_meas_s main_meas = '0, aux_meas = '0;
	logic pready, pslverr, err, mini_holdover, divider_reset, build_out_allowed, aux_lock_disable;
	logic signed [16:0] feedback_offset;
	logic [3:0] aux_forced_input_select, main_bw_select;
	logic [1:0] aux_bw_select;
	logic dr_q = 0;
	int errors = 0, checks_done = 0, rises = 0, n;
	dpm_top dpm_top_i (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .main_loop_state, .build_out_event, .main_meas, .aux_meas,
		.main_ref_lock_mode, .forced_ref_lock_mode, .feedback_offset, .mini_holdover,
		.divider_reset, .build_out_allowed, .aux_lock_disable, .aux_forced_input_select,
		.copy_lock_mode, .main_bw_select, .aux_bw_select);
	initial forever #10 clk = ~clk;
	always @(posedge clk)
	begin
		dr_q <= divider_reset;
		if (divider_reset && !dr_q)
			rises++;
	end
	task print_verdict();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Entered and left just after a rising edge; one idle cycle keeps drives apart
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		n = 0;
		do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (n == 20)
		begin
			errors++;
			print_verdict();
		end
		@(posedge clk);
	endtask
	// Ends on a falling edge, except offset waits which check and resume
	task wait_for(input int sel, input logic signed [16:0] t);
		n = 0;
		do @(negedge clk); while (!(sel == 0 ? feedback_offset === t : sel == 1 ?
			divider_reset === 1'b1 : mini_holdover === 1'b0) && ++n < 600);
		if (n == 600)
			errors++;
		if (n == 600)
			print_verdict();
		if (sel == 0)
			check(feedback_offset, t);
		if (sel == 0)
			@(posedge clk);
	endtask
	// Byte-wide pieces, lowest first; not atomic, so inputs stay still meanwhile
	task rdf(input logic [11:0] a, input int cnt, input logic [23:0] e);
		for (int i = 0; i < cnt; i++)
		begin
			apb(0, a + 12'(4 * i), 0);
			check(rd, {24'h0, e[8 * i +: 8]});
		end
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		resetn <= 1;
		@(negedge clk);
		check(feedback_offset, 0);
		check(build_out_allowed, 0);
		@(posedge clk);
		apb(0, `DPM_ADDR_CTRL, 0);
		check(rd, `DPM_CTRL_RESET);
		apb(1, `DPM_ADDR_OFFSET, 25);
		wait_for(0, 25);
		apb(1, `DPM_ADDR_OFFSET, 32'h0000_FFFF);
		apb(0, `DPM_ADDR_OFFSET, 0);
		check(rd, 32'h0000_8235);
		apb(1, `DPM_ADDR_OFFSET, 32'hFFFF_FFFB);
		wait_for(0, -5);
		apb(0, `DPM_ADDR_OFFSET, 0);
		check(rd, 32'hFFFF_FFFB);
		main_loop_state <= DPM_ST_HOLDOVER;
		apb(1, `DPM_ADDR_OFFSET, 40);
		repeat (40) @(posedge clk);
		check(feedback_offset, -5);
		main_loop_state <= DPM_ST_LOCKING;
		wait_for(0, 40);
		$display("test offset done");
		apb(1, `DPM_ADDR_CTRL, 1);
		apb(1, `DPM_ADDR_OFFSET, 10);
		repeat (30) @(posedge clk);
		check(feedback_offset, 40);
		apb(1, `DPM_ADDR_CTRL, 0);
		wait_for(0, 10);
		$display("test build-out done");
		apb(1, `DPM_ADDR_CTRL, 2);
		wait_for(1, 0);
		check(feedback_offset, 0);
		check(mini_holdover, 1);
		@(posedge clk);
		apb(0, `DPM_ADDR_STATUS, 0);
		check(rd, 32'h0000_0063);
		apb(1, `DPM_ADDR_OFFSET, 15);
		apb(1, `DPM_ADDR_CTRL, 2);
		wait_for(2, 0);
		check(feedback_offset, 15);
		check(rises, 1);
		@(posedge clk);
		$display("test recalibration done");
		apb(1, `DPM_ADDR_CTRL, 4);
		apb(1, `DPM_ADDR_AUXCFG, 9);
		for (int f = 0; f < 4; f++)
			for (int m = 0; m < 4; m++)
			begin
				@(posedge clk);
				forced_ref_lock_mode <= 2'(f);
				main_ref_lock_mode <= 2'(m);
				@(negedge clk);
				check(copy_lock_mode, (f == 1 || f == 2) ?
					(m == 3 ? 0 : (m == 2 ? 2 : 1)) : 0);
			end
		check(aux_lock_disable, 1);
		check(aux_forced_input_select, 9);
		check(feedback_offset, 15);
		@(posedge clk);
		$display("test cross done");
		main_meas.freq <= 24'h012345;
		aux_meas.freq <= 24'hFEDCBA;
		main_meas.phase <= 16'h0123;
		aux_meas.phase <= 16'hFF00;
		apb(1, `DPM_ADDR_CTRL, 0);
		rdf(`DPM_ADDR_FREQ_MEASURE_PART_ONE, 3, 24'h012345);
		// Averaging filter needs about a hundred cycles to settle
		repeat (300) @(posedge clk);
		rdf(`DPM_ADDR_PHASE_MEASURE_PART_ONE, 2, 24'h000123);
		apb(1, `DPM_ADDR_CTRL, 8);
		rdf(`DPM_ADDR_FREQ_MEASURE_PART_ONE, 3, 24'hFEDCBA);
		repeat (300) @(posedge clk);
		rdf(`DPM_ADDR_PHASE_MEASURE_PART_ONE, 2, 24'h00FF00);
		main_meas.freq <= 24'h050000;
		apb(1, `DPM_ADDR_CTRL, 0);
		rdf(`DPM_ADDR_FREQ_MEASURE_PART_ONE, 3, 24'h03FA94);
		apb(0, 12'h030, 0);
		check(rd, 0);
		check(err, 1);
		apb(1, `DPM_ADDR_BW, 32'h0000_020C);
		apb(1, `DPM_ADDR_BW, 32'h0000_030D);
		apb(0, `DPM_ADDR_BW, 0);
		check(rd, 32'h0000_020C);
		check(main_bw_select, 12);
		check(aux_bw_select, 2);
		$display("test measurement done");
		print_verdict();
	end
endmodule
